// *** include/pmu_pkg.sv ***
package pmu_pkg;
  // register byte offsets
  localparam logic [11:0] SLEEP_CFG_OFFSET   = 12'h020;
  localparam logic [11:0] GATE_CTRL_OFFSET   = 12'h024;
  localparam logic [11:0] RESET_CAUSE_OFFSET = 12'h010;
  localparam logic [31:0] SLEEP_CFG_RESET    = 32'h0137_0004;
  localparam logic [7:0]  GATE_CTRL_RESET    = 8'h50;
  localparam logic [31:0] SLEEP_CFG_WMASK    = 32'h073f_3f0f;

  // sleep_cycle_config fields
  localparam int SENSE_DELAY_LSB = 24;
  localparam int WAKE_EXP_LSB    = 20;
  localparam int WAKE_MANT_LSB   = 16;
  localparam int SENSE_EXP_LSB   = 12;
  localparam int SENSE_MANT_LSB  = 8;
  localparam int SENSE_EN_BIT    = 3;
  localparam int WAKE_EN_BIT     = 2;
  localparam int VREDUCE_N_BIT   = 1;
  localparam int WAKE_RST_BIT    = 0;

  // gate_drive_cycle_control fields
  localparam int GATE_OFF_LSB    = 6;
  localparam int GATE_ON_LSB     = 4;
  localparam int GB_HOLD_BIT     = 3;
  localparam int GB_CYC_BIT      = 2;
  localparam int GA_HOLD_BIT     = 1;
  localparam int GA_CYC_BIT      = 0;

  // reset cause bits; bit 10 is internal only
  localparam logic [10:0] F_REGFAIL   = 11'h001;
  localparam logic [10:0] F_STOPEXIT  = 11'h002;
  localparam logic [10:0] F_SLEEPEXIT = 11'h004;
  localparam logic [10:0] F_EXTWDT    = 11'h020;
  localparam logic [10:0] F_PIN       = 11'h040;
  localparam logic [10:0] F_POR       = 11'h080;
  localparam logic [10:0] F_INTWDT    = 11'h100;
  localparam logic [10:0] F_SOFT      = 11'h200;
  localparam logic [10:0] F_WDTSEQ    = 11'h400;
  localparam logic [10:0] CAUSE_RD_MASK = 11'h3e7;
  localparam logic [10:0] TYPE1_MASK  = F_POR | F_REGFAIL | F_WDTSEQ;
  localparam logic [10:0] TYPE2_MASK  = TYPE1_MASK | F_PIN | F_EXTWDT | F_INTWDT | F_SOFT
                                        | F_STOPEXIT;
  localparam logic [10:0] TYPE3_MASK  = TYPE2_MASK | F_SLEEPEXIT;

  // synchroniser lanes
  localparam int SYN_EXTWDT = 0;
  localparam int SYN_WDTSEQ = 1;
  localparam int SYN_REGFAIL = 2;
  localparam int SYN_SOFT = 3;
  localparam int SYN_INTWDT = 4;
  localparam int SYN_SLEEPWAKE = 5;
  localparam int SYN_STOPWAKE = 6;
  localparam int SYN_MON = 7;

  // timing: one backup clock tick per microsecond
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_US         = 1;
  localparam int LP_TICK_DEFAULT = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int OFF_UNIT_MS     = 2;
  localparam int OFF_UNIT_TICKS  = OFF_UNIT_MS * 1000 / TICK_US;
  localparam int PIN_MIN_NS      = 500;
  localparam logic [7:0] PIN_STABLE_CNT = 8'(PIN_MIN_NS / CLK_PERIOD_NS + 1);
  localparam int SAMPLE_DELAY_US [8] = '{18, 27, 36, 45, 63, 81, 99, 144};
  localparam int GATE_OFF_US [4] = '{400, 800, 2000, 4000};
  localparam int GATE_ON_US [4]  = '{50, 100, 200, 400};
  localparam int SENSE_WINDOW_TICKS = 4;
  localparam int EXT_WDT_DELAY_TICKS = 8;
  localparam int RESET_HOLD_TICKS = 4;
  localparam int POWERUP_TICKS = 10;
  localparam int TIME_W = 21;

  typedef enum logic [2:0] {
    ST_POWERUP  = 3'b000,
    ST_ACTIVE   = 3'b001,
    ST_RESET    = 3'b011,
    ST_WDT_WAIT = 3'b010,
    ST_SLEEP    = 3'b110
  } rst_state_t;

  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_OFF   = 2'b01,
    CS_DELAY = 2'b11,
    CS_SENSE = 2'b10
  } sense_state_t;
endpackage

// *** verilog/lp_tick_gen.sv ***
`timescale 1ns/100ps
module lp_tick_gen #(
  parameter int unsigned DIV = 100
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_state_t;

  tick_state_t q;
  tick_state_t d;

  always_comb begin
    d = q;
    d.tick = (q.cnt == 16'(DIV - 1));
    d.cnt = d.tick ? 16'h0 : q.cnt + 16'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule

// *** verilog/reset_pin_filter.sv ***
`timescale 1ns/100ps
module reset_pin_filter (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_reset_n,
  input  wire logic accept,
  output logic      req
);
  import pmu_pkg::*;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic [7:0] cnt;
    logic       req;
  } pin_state_t;

  pin_state_t q;
  pin_state_t d;

  always_comb begin
    d = q;
    d.s1 = pin_reset_n;
    d.s2 = q.s1;
    d.req = 1'b0;
    if (q.s2) begin
      d.cnt = 8'h0;
    end else if (q.cnt != PIN_STABLE_CNT) begin
      d.cnt = q.cnt + 8'h1;
      d.req = accept && (q.cnt == PIN_STABLE_CNT - 8'd1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.s1 <= 1'b1;
      q.s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign req = q.req;

  chk_pin_width_gate:
  assert property (@(posedge clk) disable iff (rst)
    req |-> (q.cnt == PIN_STABLE_CNT) && $past(accept) && $past(!q.s2))
    else $error("pin reset taken without stable low or while gated");
endmodule

// *** verilog/pmu_cyc_rst.sv ***
// Design decision made here: the APB register port.
`timescale 1ns/100ps
// Function
// - sense off time 4^e*(m+1)*2ms
// - wake off time same formula, wake fields
// - sample delay code after supply on
// - all cyclic times from backup clock
// - sense enable gates cyclic sensing
// - wake enable gates timed wake-up
// - low reduce bit requests 0.9V in Stop
// - optional reset on Stop exit, flagged
// - gate off time 400/800/2000/4000us
// - gate on time 50/100/200/400us
// - hold enable bits per gate
// - cycle enable bits per gate
// - power-up sequence then release, flag POR
// - Sleep exit repeats power-up, own flag
// - pin reset stable, Active/Stop, not during reset
// - pin reset in Stop wakes, flags pin
// - external watchdog miss in Active, not Stop: flags, delayed reset
// - soft and internal watchdog, lowest priority
// - regulator failure resets then enters Sleep
// - type0 POR only, type1 adds failures
// - type2 adds Active resets, type3 sleep
// - monitor wake only inside sensing window
module pmu_cyc_rst #(
  parameter int unsigned LP_TICK_CYCLES = pmu_pkg::LP_TICK_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_mode,
  input  wire logic        sleep_request,
  input  wire logic        reset_pin_n,
  input  wire logic        ext_watchdog_miss,
  input  wire logic        watchdog_sequence_failure,
  input  wire logic        regulator_failure,
  input  wire logic        soft_reset_req,
  input  wire logic        int_watchdog_req,
  input  wire logic        sleep_wake_req,
  input  wire logic        stop_wake_req,
  input  wire logic        monitor_input,
  output logic             mcu_reset_n,
  output logic             mcu_wake,
  output logic      [3:0]  reset_type,
  output logic             supply_gating_window,
  output logic             sense_wake_pulse,
  output logic             timed_wake_pulse,
  output logic             core_voltage_reduce_n,
  output logic             gate_a_on,
  output logic             gate_b_on,
  output logic             gate_a_hold,
  output logic             gate_b_hold,
  output logic             sleep_active
);
  import pmu_pkg::*;

  typedef struct packed {
    rst_state_t        st;
    sense_state_t      sst;
    logic [7:0]        s1;
    logic [7:0]        s2;
    logic [TIME_W-1:0] seq_cnt;
    logic [TIME_W-1:0] sense_cnt;
    logic [TIME_W-1:0] wake_cnt;
    logic [TIME_W-1:0] gate_cnt;
    logic              gate_phase;
    logic [31:0]       sleep_cfg;
    logic [7:0]        gate_cfg;
    logic [10:0]       flags;
    logic [10:0]       cause;
    logic              go_sleep;
    logic              window;
    logic              sense_hold;
    logic              gate_win;
    logic              sense_wake;
    logic              timed_wake;
    logic              mcu_wake;
    logic              mcu_reset_n;
    logic              vred_n;
    logic [3:0]        rtype;
    logic              ga_on;
    logic              gb_on;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              sleep_on;
  } pmu_state_t;

  pmu_state_t q;
  pmu_state_t d;
  logic       tick;
  logic       pin_req;
  logic       pin_accept;
  logic [7:0] async_in;

  function automatic logic [TIME_W-1:0] off_load(input logic [1:0] e, input logic [3:0] m);
    logic [31:0] units;
    units = ({28'h0, m} + 32'h1) << {e, 1'b0};
    off_load = TIME_W'(units * 32'(OFF_UNIT_TICKS) - 32'h1);
  endfunction

  function automatic logic [TIME_W-1:0] delay_load(input logic [2:0] code);
    delay_load = TIME_W'(SAMPLE_DELAY_US[code] / TICK_US - 1);
  endfunction

  function automatic logic [1:0] reg_index(input logic [11:0] addr);
    if (addr == SLEEP_CFG_OFFSET) begin
      reg_index = 2'd1;
    end else if (addr == GATE_CTRL_OFFSET) begin
      reg_index = 2'd2;
    end else if (addr == RESET_CAUSE_OFFSET) begin
      reg_index = 2'd3;
    end else begin
      reg_index = 2'd0;
    end
  endfunction

  lp_tick_gen #(
    .DIV (LP_TICK_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  assign pin_accept = (q.st == ST_ACTIVE);

  reset_pin_filter u_pin (
    .clk         (clk),
    .rst         (rst),
    .pin_reset_n (reset_pin_n),
    .accept      (pin_accept),
    .req         (pin_req)
  );

  assign async_in = {monitor_input, stop_wake_req, sleep_wake_req, int_watchdog_req,
                     soft_reset_req, regulator_failure, watchdog_sequence_failure,
                     ext_watchdog_miss};

  always_comb begin
    logic [10:0] set_f;
    logic [10:0] keep_f;
    logic        ps;
    logic        sense_run;
    logic        wake_run;
    logic        wake_evt;
    logic        wr;
    logic [1:0]  sel;
    set_f = '0;
    keep_f = '1;
    d = q;
    ps = stop_mode || (q.st == ST_SLEEP);
    sense_run = q.sleep_cfg[SENSE_EN_BIT] && ps;
    wake_run = q.sleep_cfg[WAKE_EN_BIT] && ps;
    wake_evt = q.sense_wake || q.timed_wake;
    sel = reg_index(paddr);
    wr = psel && penable && q.pready && pwrite;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.sense_wake = 1'b0;
    d.timed_wake = 1'b0;
    d.mcu_wake = 1'b0;

    // apb slave: zero wait states, error on unmapped word
    d.pready = psel && !penable;
    d.pslverr = psel && !penable && (sel == 2'd0);
    if (psel && !penable) begin
      d.prdata = 32'h0;
      if (!pwrite && sel == 2'd1) begin
        d.prdata = q.sleep_cfg;
      end else if (!pwrite && sel == 2'd2) begin
        d.prdata = {24'h0, q.gate_cfg};
      end else if (!pwrite && sel == 2'd3) begin
        d.prdata = {21'h0, q.flags & CAUSE_RD_MASK};
      end
    end
    if (wr && sel == 2'd1) begin
      d.sleep_cfg = pwdata & SLEEP_CFG_WMASK;
    end
    if (wr && sel == 2'd2) begin
      d.gate_cfg = pwdata[7:0];
    end
    if (wr && sel == 2'd3) begin
      keep_f = pwdata[10:0] | ~CAUSE_RD_MASK;
    end

    if (!q.sleep_cfg[SENSE_EN_BIT]) begin
      d.sense_hold = 1'b0;
    end
    if (!sense_run) begin
      d.sst = CS_IDLE;
      d.window = 1'b0;
    end else begin
      case (q.sst)
        CS_IDLE: begin
          d.sst = CS_OFF;
          d.sense_cnt = off_load(q.sleep_cfg[SENSE_EXP_LSB +: 2],
                                 q.sleep_cfg[SENSE_MANT_LSB +: 4]);
        end
        CS_OFF: begin
          if (tick && q.sense_cnt == '0) begin
            d.sst = CS_DELAY;
            d.window = 1'b1;
            d.sense_cnt = delay_load(q.sleep_cfg[SENSE_DELAY_LSB +: 3]);
          end else if (tick) begin
            d.sense_cnt = q.sense_cnt - 1'b1;
          end
        end
        CS_DELAY: begin
          if (tick && q.sense_cnt == '0) begin
            d.sst = CS_SENSE;
            d.sense_cnt = TIME_W'(SENSE_WINDOW_TICKS - 1);
          end else if (tick) begin
            d.sense_cnt = q.sense_cnt - 1'b1;
          end
        end
        CS_SENSE: begin
          if (q.s2[SYN_MON]) begin
            d.sense_wake = 1'b1;
            d.sense_hold = 1'b1;
            d.window = 1'b0;
            d.sst = CS_IDLE;
          end else if (tick && q.sense_cnt == '0) begin
            d.sst = CS_OFF;
            d.window = 1'b0;
            d.sense_cnt = off_load(q.sleep_cfg[SENSE_EXP_LSB +: 2],
                                   q.sleep_cfg[SENSE_MANT_LSB +: 4]);
          end else if (tick) begin
            d.sense_cnt = q.sense_cnt - 1'b1;
          end
        end
        default: begin
          d.sst = CS_IDLE;
        end
      endcase
    end
    // supply stays on after a sensed wake until software or the config reload on a reset turns sensing off
    d.gate_win = d.window || d.sense_hold;

    if (!wake_run) begin
      d.wake_cnt = off_load(q.sleep_cfg[WAKE_EXP_LSB +: 2], q.sleep_cfg[WAKE_MANT_LSB +: 4]);
    end else if (tick && q.wake_cnt == '0) begin
      d.timed_wake = 1'b1;
      d.wake_cnt = off_load(q.sleep_cfg[WAKE_EXP_LSB +: 2], q.sleep_cfg[WAKE_MANT_LSB +: 4]);
    end else if (tick) begin
      d.wake_cnt = q.wake_cnt - 1'b1;
    end

    if (!(q.gate_cfg[GA_CYC_BIT] || q.gate_cfg[GB_CYC_BIT])) begin
      d.gate_phase = 1'b0;
      d.gate_cnt = '0;
    end else if (tick && q.gate_cnt == '0) begin
      d.gate_phase = !q.gate_phase;
      d.gate_cnt = q.gate_phase ?
                   TIME_W'(GATE_OFF_US[q.gate_cfg[GATE_OFF_LSB +: 2]] / TICK_US - 1) :
                   TIME_W'(GATE_ON_US[q.gate_cfg[GATE_ON_LSB +: 2]] / TICK_US - 1);
    end else if (tick) begin
      d.gate_cnt = q.gate_cnt - 1'b1;
    end
    d.ga_on = d.gate_phase && q.gate_cfg[GA_CYC_BIT];
    d.gb_on = d.gate_phase && q.gate_cfg[GB_CYC_BIT];

    d.vred_n = !(stop_mode && !q.sleep_cfg[VREDUCE_N_BIT]);

    case (q.st)
      ST_POWERUP: begin
        if (tick && q.seq_cnt == '0) begin
          d.st = ST_ACTIVE;
          d.mcu_reset_n = 1'b1;
          set_f = q.cause;
          d.cause = '0;
        end else if (tick) begin
          d.seq_cnt = q.seq_cnt - 1'b1;
        end
      end
      ST_ACTIVE: begin
        if (q.s2[SYN_REGFAIL] || q.s2[SYN_WDTSEQ]) begin
          d.cause = q.s2[SYN_REGFAIL] ? F_REGFAIL : F_WDTSEQ;
          d.go_sleep = 1'b1;
          d.st = ST_RESET;
        end else if (pin_req) begin
          d.cause = stop_mode ? (F_PIN | F_STOPEXIT) : F_PIN;
          d.mcu_wake = stop_mode;
          d.st = ST_RESET;
        end else if (q.s2[SYN_EXTWDT] && !stop_mode) begin
          d.cause = F_EXTWDT;
          set_f = F_EXTWDT;
          d.st = ST_WDT_WAIT;
          d.seq_cnt = TIME_W'(EXT_WDT_DELAY_TICKS - 1);
        end else if (stop_mode && (q.s2[SYN_STOPWAKE] || wake_evt)) begin
          d.mcu_wake = 1'b1;
          if (q.sleep_cfg[WAKE_RST_BIT]) begin
            d.cause = F_STOPEXIT;
            d.st = ST_RESET;
          end
        end else if (!stop_mode && (q.s2[SYN_INTWDT] || q.s2[SYN_SOFT])) begin
          d.cause = q.s2[SYN_INTWDT] ? F_INTWDT : F_SOFT;
          d.st = ST_RESET;
        end else if (sleep_request) begin
          d.st = ST_SLEEP;
          d.mcu_reset_n = 1'b0;
        end
      end
      ST_WDT_WAIT: begin
        if (tick && q.seq_cnt == '0) begin
          d.st = ST_RESET;
        end else if (tick) begin
          d.seq_cnt = q.seq_cnt - 1'b1;
        end
      end
      ST_RESET: begin
        if (tick && q.seq_cnt == '0) begin
          d.st = q.go_sleep ? ST_SLEEP : ST_ACTIVE;
          d.mcu_reset_n = !q.go_sleep;
          d.go_sleep = 1'b0;
          d.cause = '0;
        end else if (tick) begin
          d.seq_cnt = q.seq_cnt - 1'b1;
        end
      end
      ST_SLEEP: begin
        if (q.s2[SYN_SLEEPWAKE] || wake_evt) begin
          d.st = ST_POWERUP;
          d.cause = F_SLEEPEXIT;
          d.seq_cnt = TIME_W'(POWERUP_TICKS - 1);
        end
      end
      default: begin
        d.st = ST_POWERUP;
      end
    endcase
    d.sleep_on = (d.st == ST_SLEEP);

    // entering a reset: hold the core, record the source, reload type-2 config
    if (d.st == ST_RESET && q.st != ST_RESET) begin
      d.mcu_reset_n = 1'b0;
      d.seq_cnt = TIME_W'(RESET_HOLD_TICKS - 1);
      d.sleep_cfg = SLEEP_CFG_RESET;
      set_f = set_f | d.cause;
    end
    // a flag set in the cycle software clears it survives
    d.flags = (q.flags & keep_f) | (set_f & CAUSE_RD_MASK);

    if (d.st == ST_POWERUP || d.st == ST_RESET) begin
      d.rtype = {|(d.cause & TYPE3_MASK), |(d.cause & TYPE2_MASK),
                 |(d.cause & TYPE1_MASK), |(d.cause & F_POR)};
    end else begin
      d.rtype = 4'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_POWERUP;
      q.sst <= CS_IDLE;
      q.cause <= F_POR;
      q.seq_cnt <= TIME_W'(POWERUP_TICKS - 1);
      q.sleep_cfg <= SLEEP_CFG_RESET;
      q.gate_cfg <= GATE_CTRL_RESET;
      q.vred_n <= 1'b1;
      q.rtype <= 4'hf;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign mcu_reset_n = q.mcu_reset_n;
  assign mcu_wake = q.mcu_wake;
  assign reset_type = q.rtype;
  assign supply_gating_window = q.gate_win;
  assign sense_wake_pulse = q.sense_wake;
  assign timed_wake_pulse = q.timed_wake;
  assign core_voltage_reduce_n = q.vred_n;
  assign gate_a_on = q.ga_on;
  assign gate_b_on = q.gb_on;
  assign gate_a_hold = q.gate_cfg[GA_HOLD_BIT];
  assign gate_b_hold = q.gate_cfg[GB_HOLD_BIT];
  assign sleep_active = q.sleep_on;

  chk_sense_off_load:
  assert property (@(posedge clk) disable iff (rst)
    ($past(q.sst) == CS_IDLE && q.sst == CS_OFF) |->
      q.sense_cnt == off_load($past(q.sleep_cfg[SENSE_EXP_LSB +: 2]),
                              $past(q.sleep_cfg[SENSE_MANT_LSB +: 4])))
    else $error("sense off time loaded wrong");

  chk_wake_reload:
  assert property (@(posedge clk) disable iff (rst)
    timed_wake_pulse |-> q.wake_cnt == off_load($past(q.sleep_cfg[WAKE_EXP_LSB +: 2]),
                                                $past(q.sleep_cfg[WAKE_MANT_LSB +: 4])))
    else $error("timed wake interval loaded wrong");

  chk_sample_delay:
  assert property (@(posedge clk) disable iff (rst)
    ($past(q.sst) == CS_OFF && q.sst == CS_DELAY) |->
      supply_gating_window &&
      q.sense_cnt == delay_load($past(q.sleep_cfg[SENSE_DELAY_LSB +: 3])))
    else $error("sample delay wrong after supply on");

  chk_sense_disabled:
  assert property (@(posedge clk) disable iff (rst)
    !q.sleep_cfg[SENSE_EN_BIT] |=> q.sst == CS_IDLE && !sense_wake_pulse)
    else $error("sensing ran while disabled");

  chk_timed_wake_off:
  assert property (@(posedge clk) disable iff (rst)
    !q.sleep_cfg[WAKE_EN_BIT] |=> !timed_wake_pulse)
    else $error("timed wake fired while disabled");

  chk_voltage_reduce:
  assert property (@(posedge clk) disable iff (rst)
    (stop_mode && !q.sleep_cfg[VREDUCE_N_BIT]) |=> !core_voltage_reduce_n)
    else $error("reduction not requested in stop");

  chk_release_flag:
  assert property (@(posedge clk) disable iff (rst)
    ($past(q.st) == ST_POWERUP && q.st == ST_ACTIVE) |->
      mcu_reset_n && (q.flags & (F_POR | F_SLEEPEXIT)) != 11'h0)
    else $error("release without power-up flag");

  chk_type_nesting:
  assert property (@(posedge clk) disable iff (rst)
    (reset_type[0] |-> reset_type[1]) and (reset_type[1] |-> reset_type[2])
      and (reset_type[2] |-> reset_type[3]))
    else $error("reset types not nested");

  chk_window_accept:
  assert property (@(posedge clk) disable iff (rst)
    sense_wake_pulse |-> $past(supply_gating_window))
    else $error("monitor wake taken outside window");
endmodule

// *** dv/pin_reset_model.sv ***
`timescale 1ns/100ps
module pin_reset_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            reset_pin_n,
  output logic            busy
);
  logic [7:0] cnt = 8'h00;
  logic       go_q = 1'b0;
  initial reset_pin_n = 1'b1;
  assign busy = cnt != 8'h00;
  always @(posedge clk) begin
    go_q <= go;
    if (go && !go_q && !busy) begin
      cnt <= len;
      reset_pin_n <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
      reset_pin_n <= cnt == 8'h01;
    end
  end
endmodule

// *** dv/test_pmu_cyc_rst.sv ***
`timescale 1ns/100ps
module test_pmu_cyc_rst;
  import pmu_pkg::*;
  // writable fields: 26:24, 21:16, 13:8, 3:0
  localparam logic [31:0] SLEEP_RW = 32'h073f_3f0f;
  localparam logic [10:0] FLAG [5] = '{F_SOFT, F_INTWDT, F_EXTWDT, F_PIN, F_REGFAIL};
  localparam int          LP = 2;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  src = 5'h00;
  logic        sleep_wake = 1'b0;
  logic [7:0]  pin_len = 8'h00;
  logic        pin_n;
  logic        mcu_reset_n;
  logic [3:0]  reset_type;
  logic        sleep_active;
  logic        gate_a_hold;
  logic        gate_b_hold;
  logic        stop = 1'b0;
  logic        mon = 1'b0;
  logic        mcu_wake;
  logic        core_voltage_reduce_n;
  logic        gate_a_on;
  logic        gate_b_on;
  logic        supply_gating_window;
  logic        sense_wake_pulse;
  int          miscompares = 0;
  int          n_tests = 0;
  int          n = 0;
  int          n_wake = 0;
  logic [31:0] q;
  logic        e;
  logic [31:0] d;
  always #5 clk = ~clk;
  pmu_cyc_rst #(.LP_TICK_CYCLES(LP)) uut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop),
    .sleep_request(1'b0), .reset_pin_n(pin_n), .ext_watchdog_miss(src[2]),
    .watchdog_sequence_failure(1'b0), .regulator_failure(src[4]), .soft_reset_req(src[0]),
    .int_watchdog_req(src[1]), .sleep_wake_req(sleep_wake), .stop_wake_req(1'b0),
    .monitor_input(mon), .mcu_reset_n(mcu_reset_n), .mcu_wake(mcu_wake),
    .reset_type(reset_type), .supply_gating_window(supply_gating_window),
    .sense_wake_pulse(sense_wake_pulse), .timed_wake_pulse(),
    .core_voltage_reduce_n(core_voltage_reduce_n), .gate_a_on(gate_a_on),
    .gate_b_on(gate_b_on), .gate_a_hold(gate_a_hold),
    .gate_b_hold(gate_b_hold), .sleep_active(sleep_active));
  pin_reset_model pin_model (.clk(clk), .go(src[3]), .len(pin_len), .reset_pin_n(pin_n),
    .busy());
  // core wake pulses seen over the whole run
  always @(posedge clk) begin
    if (mcu_wake === 1'b1) begin
      n_wake <= n_wake + 1;
    end
  end
  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    i = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (i == 20) begin
      miscompares++;
      finish_test();
    end
  endtask
  // sel 0 core reset, 1 sleep state, 2 gate a, 3 sensed wake; n counts the cycles waited
  task automatic wait_for(input int sel, input logic v);
    n = 0;
    while ((sel == 3 ? sense_wake_pulse : sel == 2 ? gate_a_on : sel ? sleep_active :
            mcu_reset_n) !== v && n < 10000) begin
      @(posedge clk);
      n++;
    end
    if (n == 10000) begin
      miscompares++;
      finish_test();
    end
  endtask
  function automatic logic [3:0] exp_type(input logic [10:0] f);
    exp_type = {2'b11, |(f & (F_POR | F_REGFAIL | F_WDTSEQ)), f == F_POR};
  endfunction
  initial begin
    void'($urandom(32'h35797a35));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_for(0, 1'b1);
    apb(1'b0, RESET_CAUSE_OFFSET, 32'h0);
    check(q & 32'h3e7, 32'h80);
    check(reset_type, 32'h0);
    apb(1'b0, SLEEP_CFG_OFFSET, 32'h0);
    check(q, 32'h0137_0004);
    apb(1'b0, GATE_CTRL_OFFSET, 32'h0);
    check(q, 32'h50);
    apb(1'b0, 12'h040, 32'h0);
    check({q[30:0], e}, 32'h1);
    d = $urandom;
    apb(1'b1, GATE_CTRL_OFFSET, d);
    apb(1'b0, GATE_CTRL_OFFSET, 32'h0);
    check(q, d & 32'hff);
    check({gate_b_hold, gate_a_hold}, {d[3], d[1]});
    // a pulse shorter than the filter must be lost
    pin_len <= 8'd30;
    src[3] <= 1'b1;
    repeat (100) @(posedge clk);
    check(mcu_reset_n, 32'h1);
    src[3] <= 1'b0;
    pin_len <= 8'd80;
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, RESET_CAUSE_OFFSET, 32'h0);
      d = $urandom;
      apb(1'b1, SLEEP_CFG_OFFSET, d);
      apb(1'b0, SLEEP_CFG_OFFSET, 32'h0);
      check(q, d & SLEEP_RW);
      src[k] <= 1'b1;
      wait_for(0, 1'b0);
      check(reset_type, exp_type(FLAG[k]));
      src[k] <= 1'b0;
      if (k == 4) begin
        wait_for(1, 1'b1);
        check(mcu_reset_n, 32'h0);
        sleep_wake <= 1'b1;
      end
      wait_for(0, 1'b1);
      sleep_wake <= 1'b0;
      apb(1'b0, RESET_CAUSE_OFFSET, 32'h0);
      // the restart after a failure flags Sleep exit, not power-on; the power-on bit is masked anyway
      check(q & (CAUSE_RD_MASK & ~F_POR), FLAG[k] | (k == 4 ? F_SLEEPEXIT : 11'h0));
      apb(1'b0, SLEEP_CFG_OFFSET, 32'h0);
      check(q, 32'h0137_0004);
    end
    // Stop: reduction request, then a pin reset that also wakes the core
    stop <= 1'b1;
    apb(1'b1, RESET_CAUSE_OFFSET, 32'h0);
    check(core_voltage_reduce_n, 32'h0);
    src[3] <= 1'b1;
    wait_for(0, 1'b0);
    check(reset_type, exp_type(F_PIN | F_STOPEXIT));
    src[3] <= 1'b0;
    wait_for(0, 1'b1);
    apb(1'b0, RESET_CAUSE_OFFSET, 32'h0);
    check(q & CAUSE_RD_MASK, F_PIN | F_STOPEXIT);
    // shortest timed wake with reset on Stop exit; disable first to reload the interval
    apb(1'b1, RESET_CAUSE_OFFSET, 32'h0);
    apb(1'b1, SLEEP_CFG_OFFSET, 32'h0);
    apb(1'b1, SLEEP_CFG_OFFSET, 32'h5);
    wait_for(0, 1'b0);
    check(n / LP, OFF_UNIT_TICKS);
    wait_for(0, 1'b1);
    apb(1'b0, RESET_CAUSE_OFFSET, 32'h0);
    check(q & CAUSE_RD_MASK, F_STOPEXIT);
    // sensed wake in Stop; the tick phase leaves one tick of slack
    mon <= 1'b1;
    apb(1'b1, SLEEP_CFG_OFFSET, 32'h8);
    wait_for(3, 1'b1);
    d = OFF_UNIT_TICKS + SAMPLE_DELAY_US[0];
    check(n / LP - d < 2, 32'h1);
    repeat (4) @(posedge clk);
    check(supply_gating_window, 32'h1);
    mon <= 1'b0;
    apb(1'b1, SLEEP_CFG_OFFSET, 32'h0);
    stop <= 1'b0;
    repeat (2) @(posedge clk);
    check(supply_gating_window, 32'h0);
    check(core_voltage_reduce_n, 32'h1);
    check(n_wake, 32'h3);
    // both gates cycling with random codes, on phase first
    apb(1'b1, GATE_CTRL_OFFSET, 32'h0);
    d = ($urandom & 32'hf0) | 32'h5;
    apb(1'b1, GATE_CTRL_OFFSET, d);
    wait_for(2, 1'b1);
    check(gate_b_on, 32'h1);
    wait_for(2, 1'b0);
    check(n, GATE_ON_US[d[5:4]] / TICK_US * LP);
    wait_for(2, 1'b1);
    check(n, GATE_OFF_US[d[7:6]] / TICK_US * LP);
    finish_test();
  end
endmodule
